// ===== mam_core.sv
// Summary of operation
// - Code 93 xx D8 yy is add-with-move; byte two pointers, byte four pointer ops.
// - Code 93 xx D9 yy is the rounding add-with-move, same field layout.
// - Signed 16x16 product to 32 bits, sign-extended to accumulator width.
// - Product shift mode set doubles the extended product before accumulating.
// - Add form: accumulator plus prepared product stored back.
// - Subtract form: accumulator minus prepared product stored back.
// - In parallel, word at index pointer is copied elsewhere in dual-port RAM.
// - Move destination comes from the index pointer modification.
// - Add form: overflow flag set if result exceeds 40 signed bits, else cleared.
// - Subtract form: overflow flag set on underflow beyond 40 bits, else cleared.
// - Saturation flag set when result is saturated, otherwise unchanged.
// - Extension-used flag set when bits above low 32 matter, else cleared.
// - Sticky overflow set on any overflow or underflow, otherwise unchanged.
// - Carry flag set on add carry or subtract borrow, else cleared.
// - Zero flag set when stored result is zero, else cleared.
// - Negative flag follows bit 39 of the stored result.
// - Rounding variant adds 00 0000 8000h before storing.
// - Rounding variant clears the accumulator low word.
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
module mam_core
    import mam_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [mam_pkg::WB_ADR_W-1:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input mam_pkg::mam_req_t host_req,
    output logic host_ready,
    output logic op_done,
    output mam_pkg::mam_ram_t ram_req,
    input wire logic [mam_pkg::DATA_W-1:0] ram_rd_data,
    output mam_pkg::mam_flags_t flags,
    output logic [mam_pkg::ACC_W-1:0] wide_accumulator,
    output logic irq
);
    import mam_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mam_state_t st;
        logic [ACC_W-1:0] acc;
        mam_flags_t flags;
        logic product_shift_mode;
        logic sat_enable;
        mam_irq_t irq_stat;
        mam_irq_t irq_mask;
        logic ack;
        logic [31:0] dat;
        logic [ADDR_W-1:0] move_dest;
        mam_ram_t ram;
        logic done;
    } mam_core_state_t;

    mam_core_state_t r_reg;
    mam_core_state_t r_next;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic fits_acc(input logic [WIDE_W-1:0] v);
        fits_acc = (v[WIDE_W-1:ACC_W-1] == '0) || (v[WIDE_W-1:ACC_W-1] == '1);
    endfunction : fits_acc

    function automatic logic [WIDE_W-1:0] widen(input logic [ACC_W-1:0] v);
        widen = {{(WIDE_W-ACC_W){v[ACC_W-1]}}, v};
    endfunction : widen

    logic go;
    logic legal;
    logic is_add;
    logic is_rnd;
    logic is_sub;
    logic signed [PROD_W-1:0] prod;
    logic [WIDE_W-1:0] prep;
    logic [WIDE_W-1:0] rnd;
    logic [WIDE_W-1:0] raw;
    logic [ACC_W:0] ucarry;
    logic ovf;
    logic carry;
    logic sat;
    logic [ACC_W-1:0] res;
    logic wb_req;
    logic wb_wr;
    mam_flags_t fl;
    mam_irq_t ev;
    logic [6:0] flag_clr;
    logic [3:0] irq_clr;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        ev = '0;
        flag_clr = '0;
        irq_clr = '0;
        r_next.done = 1'b0;
        r_next.ram.rd_en = 1'b0;
        r_next.ram.wr_en = 1'b0;

        // Decode of the host request
        go = host_req.valid && (r_reg.st == ST_IDLE);
        is_add = (host_req.word[15:8] == SUB_ADD) || (host_req.word[15:8] == SUB_ADD_RND);
        is_rnd = host_req.word[15:8] == SUB_ADD_RND;
        is_sub = host_req.word[15:8] == SUB_SUB;
        legal = (host_req.word[31:24] == OPC_PREFIX) && (is_add || is_sub);

        // Product, widened by two guard bits so overflow is visible
        prod = $signed(host_req.op_a) * $signed(host_req.op_b);
        prep = {{(WIDE_W-PROD_W){prod[PROD_W-1]}}, prod};
        if (r_reg.product_shift_mode) begin
            prep = {prep[WIDE_W-2:0], 1'b0};
        end
        rnd = is_rnd ? widen(ROUND_CONST) : '0;
        if (is_sub) begin
            raw = widen(r_reg.acc) - prep;
            carry = r_reg.acc < prep[ACC_W-1:0];
            ucarry = '0;
        end else begin
            raw = widen(r_reg.acc) + prep + rnd;
            ucarry = {1'b0, r_reg.acc} + {1'b0, prep[ACC_W-1:0]} + {1'b0, rnd[ACC_W-1:0]};
            carry = ucarry[ACC_W];
        end
        ovf = !fits_acc(raw);
        sat = ovf && r_reg.sat_enable;
        if (sat) begin
            res = raw[WIDE_W-1] ? ACC_MIN : ACC_MAX;
        end else begin
            res = raw[ACC_W-1:0];
        end
        if (is_rnd) begin
            res[LOW_W-1:0] = '0;
        end

        // Wishbone: ack one cycle after the strobe; writes land with ack
        wb_req = cyc_i && stb_i;
        wb_wr = wb_req && we_i && r_reg.ack;
        r_next.ack = wb_req && !r_reg.ack;
        if (wb_req && !r_reg.ack) begin
            unique case (adr_i)
                REG_CTRL: r_next.dat = 32'({r_reg.sat_enable, r_reg.product_shift_mode});
                REG_FLAGS: r_next.dat = 32'(r_reg.flags);
                REG_ACC_LO: r_next.dat = r_reg.acc[31:0];
                REG_ACC_EXT: r_next.dat = 32'(r_reg.acc[ACC_W-1:32]);
                REG_IRQ_STAT: r_next.dat = 32'(r_reg.irq_stat);
                REG_IRQ_MASK: r_next.dat = 32'(r_reg.irq_mask);
                default: r_next.dat = 32'h0000_0000;
            endcase
        end
        if (wb_wr) begin
            unique case (adr_i)
                REG_CTRL: begin
                    if (sel_i[0]) begin
                        r_next.product_shift_mode = dat_i[CTRL_MP_BIT];
                        r_next.sat_enable = dat_i[CTRL_SAT_BIT];
                    end
                end
                REG_FLAGS: begin
                    if (sel_i[0]) begin
                        flag_clr = dat_i[6:0] & FLAG_W1C_MASK;
                    end
                end
                REG_ACC_LO: begin
                    for (int b = 0; b < 4; b++) begin
                        if (sel_i[b]) begin
                            r_next.acc[8*b +: 8] = dat_i[8*b +: 8];
                        end
                    end
                end
                REG_ACC_EXT: begin
                    if (sel_i[0]) begin
                        r_next.acc[ACC_W-1:32] = dat_i[7:0];
                    end
                end
                REG_IRQ_STAT: begin
                    if (sel_i[0]) begin
                        irq_clr = dat_i[3:0];
                    end
                end
                REG_IRQ_MASK: begin
                    if (sel_i[0]) begin
                        r_next.irq_mask = mam_irq_t'(dat_i[3:0]);
                    end
                end
                default: begin
                end
            endcase
        end
        // Sticky flags: a clear and a set in one cycle leave the flag set
        fl = mam_flags_t'(7'(r_reg.flags) & ~flag_clr);

        // Instruction execution; it beats a software write to the accumulator
        unique case (r_reg.st)
            ST_IDLE: begin
                if (go && !legal) begin
                    ev.illegal = 1'b1;
                end else if (go) begin
                    r_next.acc = res;
                    fl.overflow_flag = ovf;
                    fl.saturation_limit_flag = fl.saturation_limit_flag | sat;
                    fl.extension_used_flag = !((res[ACC_W-1:31] == '0) ||
                        (res[ACC_W-1:31] == '1));
                    fl.sticky_overflow_flag = fl.sticky_overflow_flag | ovf;
                    fl.carry_flag = carry;
                    fl.zero_flag = res == '0;
                    fl.negative_flag = res[ACC_W-1];
                    ev.overflow = ovf;
                    ev.saturated = sat;
                    // Destination follows the pointer operation of byte four
                    if (host_req.word[2:0] == QQQ_KEEP) begin
                        r_next.move_dest = host_req.index_pointer;
                    end else begin
                        r_next.move_dest = host_req.index_pointer + host_req.index_step;
                    end
                    r_next.ram.rd_en = 1'b1;
                    r_next.ram.rd_addr = host_req.index_pointer;
                    r_next.st = ST_READ;
                end
            end
            ST_READ: begin
                r_next.st = ST_LOAD;
            end
            ST_LOAD: begin
                // Synchronous RAM: read data valid one cycle after the read strobe
                r_next.ram.wr_en = 1'b1;
                r_next.ram.wr_addr = r_reg.move_dest;
                r_next.ram.wr_data = ram_rd_data;
                r_next.done = 1'b1;
                r_next.st = ST_WRITE;
            end
            ST_WRITE: begin
                ev.done = 1'b1;
                r_next.st = ST_IDLE;
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase
        r_next.flags = fl;
        r_next.irq_stat = mam_irq_t'((4'(r_reg.irq_stat) & ~irq_clr) | 4'(ev));
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            r_reg <= '{st: ST_IDLE, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign dat_o = r_reg.dat;
    assign ack_o = r_reg.ack;
    // Accepting only in idle keeps the RAM copy free of overlap
    assign host_ready = r_reg.st == ST_IDLE;
    assign op_done = r_reg.done;
    assign ram_req = r_reg.ram;
    assign flags = r_reg.flags;
    assign wide_accumulator = r_reg.acc;
    assign irq = |(r_reg.irq_stat & r_reg.irq_mask);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    property p_decode;
        go && legal |=> r_reg.st == ST_READ;
    endproperty
    a_decode: assert property (p_decode) else $error("legal code not started");

    property p_add_plain;
        go && legal && host_req.word[15:8] == SUB_ADD && !r_reg.product_shift_mode && !ovf
        |=> r_reg.acc == $past(r_reg.acc) + 40'($past(prod));
    endproperty
    a_add_plain: assert property (p_add_plain) else $error("add result wrong");

    property p_sub_shift;
        go && legal && is_sub && r_reg.product_shift_mode && !ovf
        |=> r_reg.acc == $past(r_reg.acc) - (40'($past(prod)) << 1);
    endproperty
    a_sub_shift: assert property (p_sub_shift) else $error("shifted sub wrong");

    property p_round_low;
        go && legal && is_rnd |=> r_reg.acc[LOW_W-1:0] == '0;
    endproperty
    a_round_low: assert property (p_round_low) else $error("low word not cleared");

    property p_flags_nz;
        go && legal |=> r_reg.flags.negative_flag == r_reg.acc[ACC_W-1]
            && r_reg.flags.zero_flag == (r_reg.acc == '0);
    endproperty
    a_flags_nz: assert property (p_flags_nz) else $error("zero/negative flag wrong");

    property p_sticky;
        r_reg.flags.sticky_overflow_flag && !(wb_wr && adr_i == REG_FLAGS)
        |=> r_reg.flags.sticky_overflow_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("sticky overflow lost");

    property p_saturate;
        go && legal && ovf && r_reg.sat_enable && !is_rnd
        |=> (r_reg.acc == ACC_MAX || r_reg.acc == ACC_MIN)
            && r_reg.flags.saturation_limit_flag;
    endproperty
    a_saturate: assert property (p_saturate) else $error("no clamp on overflow");

    property p_move;
        go && legal |=> ram_req.rd_en ##2 ram_req.wr_en
            && ram_req.wr_addr == $past(r_reg.move_dest, 2);
    endproperty
    a_move: assert property (p_move) else $error("parallel move timing wrong");

    // Done lands in the status word in the cycle the block is ready again
    property p_irq;
        op_done |=> r_reg.irq_stat.done && host_ready;
    endproperty
    a_irq: assert property (p_irq) else $error("done event not recorded");

    property p_ack;
        ack_o |=> !ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack longer than one cycle");

    property p_ack_follow;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_follow: assert property (p_ack_follow) else $error("bus request not answered");

    property p_round_add;
        go && legal && is_rnd && !r_reg.product_shift_mode && !ovf |=> r_reg.acc[ACC_W-1:LOW_W]
            == (ACC_W-LOW_W)'(($past(r_reg.acc) + 40'($past(prod)) + ROUND_CONST) >> LOW_W);
    endproperty
    a_round_add: assert property (p_round_add) else $error("rounded sum wrong");

    property p_borrow;
        go && legal && is_sub && !r_reg.product_shift_mode
        |=> r_reg.flags.carry_flag == ($past(r_reg.acc) < 40'($past(prod)));
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow flag wrong");

    property p_ovf_sticky;
        go && legal && ovf
        |=> r_reg.flags.overflow_flag && r_reg.flags.sticky_overflow_flag;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow not flagged");

    property p_ext;
        go && legal |=> r_reg.flags.extension_used_flag
            != ((r_reg.acc[ACC_W-1:31] == '0) || (r_reg.acc[ACC_W-1:31] == '1));
    endproperty
    a_ext: assert property (p_ext) else $error("extension flag wrong");

    property p_illegal;
        go && !legal |=> r_reg.st == ST_IDLE && r_reg.irq_stat.illegal
            && r_reg.acc == $past(r_reg.acc);
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal code not refused");

    // The move needs three cycles; a second request must wait them out
    property p_busy;
        go && legal |=> !host_ready [*3] ##1 host_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("ready during parallel move");

endmodule : mam_core

// ===== mam_pkg.sv
package mam_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ACC_W = 40;
    localparam int DATA_W = 16;
    localparam int PROD_W = 32;
    localparam int WIDE_W = 42;
    localparam int ADDR_W = 16;
    localparam int WB_ADR_W = 8;
    localparam int LOW_W = 16;

    // ------------------------------------------------------------
    // Instruction encoding
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_PREFIX = 8'h93;
    localparam logic [7:0] SUB_ADD = 8'hd8;
    localparam logic [7:0] SUB_ADD_RND = 8'hd9;
    localparam logic [7:0] SUB_SUB = 8'he8;
    localparam logic [2:0] QQQ_KEEP = 3'h0;
    localparam logic [ACC_W-1:0] ROUND_CONST = 40'h00_0000_8000;
    localparam logic [ACC_W-1:0] ACC_MAX = 40'h7f_ffff_ffff;
    localparam logic [ACC_W-1:0] ACC_MIN = 40'h80_0000_0000;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [WB_ADR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [WB_ADR_W-1:0] REG_FLAGS = 8'h04;
    localparam logic [WB_ADR_W-1:0] REG_ACC_LO = 8'h08;
    localparam logic [WB_ADR_W-1:0] REG_ACC_EXT = 8'h0c;
    localparam logic [WB_ADR_W-1:0] REG_IRQ_STAT = 8'h10;
    localparam logic [WB_ADR_W-1:0] REG_IRQ_MASK = 8'h14;
    localparam int CTRL_MP_BIT = 0;
    localparam int CTRL_SAT_BIT = 1;
    localparam logic [6:0] FLAG_W1C_MASK = 7'h28;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic overflow_flag;
        logic saturation_limit_flag;
        logic extension_used_flag;
        logic sticky_overflow_flag;
        logic carry_flag;
        logic zero_flag;
        logic negative_flag;
    } mam_flags_t;

    typedef struct packed {
        logic illegal;
        logic saturated;
        logic overflow;
        logic done;
    } mam_irq_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_LOAD = 4'h4,
        ST_WRITE = 4'h8
    } mam_state_t;

    typedef struct packed {
        logic valid;
        logic [31:0] word;
        logic [DATA_W-1:0] op_a;
        logic [DATA_W-1:0] op_b;
        logic [ADDR_W-1:0] index_pointer;
        logic [ADDR_W-1:0] index_step;
    } mam_req_t;

    typedef struct packed {
        logic rd_en;
        logic [ADDR_W-1:0] rd_addr;
        logic wr_en;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] wr_data;
    } mam_ram_t;

endpackage : mam_pkg

// ===== mam_ram_model.sv
module mam_ram_model
    import mam_pkg::*;
(
    input wire logic mclk,
    input mam_pkg::mam_ram_t ram_req,
    output logic [mam_pkg::DATA_W-1:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] mem [0:65535];

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 16'(i) ^ 16'h5a3c;
        end
        rd_data = 16'h0000;
    end

    // Read data is only valid the cycle after a strobe; it toggles otherwise so that a
    // stale word can never pass for a fresh read
    always @(posedge mclk) begin
        if (ram_req.rd_en) begin
            rd_data <= mem[ram_req.rd_addr];
        end else begin
            rd_data <= ~rd_data;
        end
        if (ram_req.wr_en) begin
            mem[ram_req.wr_addr] <= ram_req.wr_data;
        end
    end
endmodule : mam_ram_model

// ===== tb.sv
module tb import mam_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, reset_n, cyc_i, stb_i, we_i, ack_o, host_ready, op_done, irq;
    logic [7:0] adr_i;
    logic [31:0] dat_i, dat_o, q;
    logic [3:0] sel_i;
    logic [15:0] ram_rd_data, ra, rb, rp, rs;
    logic [39:0] wide_accumulator, ea;
    logic [7:0] codes [3] = '{SUB_ADD, SUB_ADD_RND, SUB_SUB};
    logic [15:0] bmem [int];
    mam_req_t host_req;
    mam_ram_t ram_req;
    mam_flags_t flags, ef;
    int err_count, total_checks;

    mam_core u_dut (.mclk(mclk), .reset_n(reset_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
        .host_req(host_req), .host_ready(host_ready), .op_done(op_done), .ram_req(ram_req),
        .ram_rd_data(ram_rd_data), .flags(flags), .wide_accumulator(wide_accumulator), .irq(irq));
    mam_ram_model u_ram (.mclk(mclk), .ram_req(ram_req), .rd_data(ram_rd_data));

    always #4 mclk = ~mclk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    // Request stands until the edge that samples ack high; data is taken at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        @(posedge mclk);
        while (ack_o !== 1'b1) begin
            n++;
            @(posedge mclk);
        end
        check(n, 1, "ack latency");
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb

    task automatic op(input logic [7:0] code, input logic [15:0] a, b, input bit mp, sat,
        input logic [15:0] ip, st, input logic [2:0] qq);
        mam_req_t r;
        mam_flags_t nf;
        longint p, res;
        logic [40:0] s;
        logic [39:0] v;
        logic [15:0] rd, dst;
        bit ovf, leg;
        leg = code == SUB_ADD || code == SUB_ADD_RND || code == SUB_SUB;
        r = '{1'b1, {OPC_PREFIX, 8'h1a, code, 5'h00, qq}, a, b, ip, st};
        p = longint'($signed(a)) * longint'($signed(b));
        if (mp) p = p * 2;
        nf = ef;
        if (code == SUB_SUB) begin
            res = longint'($signed(ea)) - p;
            nf.carry_flag = ea < p[39:0];
        end else begin
            s = {1'b0, ea} + {1'b0, p[39:0]} + ((code == SUB_ADD_RND) ? 41'h8000 : 41'h0);
            res = longint'($signed(ea)) + p + ((code == SUB_ADD_RND) ? 32768 : 0);
            nf.carry_flag = s[40];
        end
        ovf = res > 64'sh7f_ffff_ffff || res < -64'sh80_0000_0000;
        v = res[39:0];
        if (ovf && sat) v = (res < 0) ? ACC_MIN : ACC_MAX;
        if (code == SUB_ADD_RND) v[15:0] = 16'h0000;
        nf.overflow_flag = ovf;
        nf.saturation_limit_flag |= ovf && sat;
        nf.extension_used_flag = !(&v[39:31] || ~|v[39:31]);
        nf.sticky_overflow_flag |= ovf;
        nf.zero_flag = v == 40'h0;
        nf.negative_flag = v[39];
        rd = bmem.exists(int'(ip)) ? bmem[int'(ip)] : ip ^ 16'h5a3c;
        dst = (qq == QQQ_KEEP) ? ip : ip + st;
        @(posedge mclk);
        host_req <= r;
        @(posedge mclk);
        while (host_ready !== 1'b1) @(posedge mclk);
        host_req.valid <= 1'b0;
        @(negedge mclk);
        if (leg) begin
            ef = nf;
            ea = v;
        end
        check(wide_accumulator, ea, "acc");
        check(flags, ef, "flags");
        check(ram_req.rd_en, leg, "rd_en");
        check(host_ready, !leg, "busy");
        if (!leg) return;
        check(ram_req.rd_addr, ip, "rd_addr");
        repeat (2) @(negedge mclk);
        check({op_done, ram_req.wr_en}, 2'b11, "write strobe");
        check(ram_req.wr_addr, dst, "move dest");
        check(ram_req.wr_data, rd, "move data");
        bmem[int'(dst)] = rd;
    endtask : op

    task automatic corner(input logic [39:0] v, input bit mp, sat, input logic [7:0] code,
        input logic [15:0] a, b);
        wb(1'b1, REG_CTRL, {30'h0, sat, mp}, q);
        wb(1'b1, REG_ACC_LO, v[31:0], q);
        wb(1'b1, REG_ACC_EXT, {24'h0, v[39:32]}, q);
        ea = v;
        op(code, a, b, mp, sat, 16'hfffe, 16'h0003, 3'h1);
    endtask : corner

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = '0;
        host_req = '0;
        ea = '0;
        ef = '0;
        err_count = 0;
        total_checks = 0;
        void'($urandom(32'he5c9));
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        @(negedge mclk);
        check({wide_accumulator, flags, irq, host_ready}, 49'h1, "reset state");
        wb(1'b0, REG_CTRL, 32'h0, q);
        check(q, 32'h0, "ctrl reset");
        for (int i = 0; i < 24; i++) begin
            ra = 16'($urandom);
            rb = 16'($urandom);
            rp = 16'($urandom);
            rs = 16'($urandom);
            wb(1'b1, REG_CTRL, {30'h0, i > 11, (i / 3) % 2 == 1}, q);
            op(codes[i % 3], ra, rb, (i / 3) % 2 == 1, i > 11, rp, rs, i[0] ? rs[2:0] : QQQ_KEEP);
        end
        corner(ACC_MAX, 1'b0, 1'b0, SUB_ADD, 16'h7fff, 16'h7fff);
        corner(ACC_MAX, 1'b1, 1'b1, SUB_ADD_RND, 16'h8000, 16'h8000);
        corner(ACC_MIN, 1'b0, 1'b1, SUB_SUB, 16'h7fff, 16'h7fff);
        corner(40'h1, 1'b0, 1'b0, SUB_SUB, 16'h0001, 16'h0001);
        corner(40'h0, 1'b0, 1'b1, SUB_SUB, 16'h0001, 16'h0001);
        corner(40'hff_ffff_8000, 1'b0, 1'b0, SUB_ADD_RND, 16'h0000, 16'h0005);
        // Software clear of the sticky flags must leave the others alone
        wb(1'b1, REG_FLAGS, 32'h7f, q);
        ef.saturation_limit_flag = 1'b0;
        ef.sticky_overflow_flag = 1'b0;
        wb(1'b0, REG_FLAGS, 32'h0, q);
        check(q, {25'h0, ef}, "flags clear");
        wb(1'b0, REG_IRQ_STAT, 32'h0, q);
        check({q[0], irq}, 2'b10, "done pending masked");
        wb(1'b1, REG_IRQ_MASK, 32'h1, q);
        @(negedge mclk);
        check(irq, 1'b1, "irq raised");
        wb(1'b1, REG_IRQ_STAT, 32'hf, q);
        @(negedge mclk);
        check(irq, 1'b0, "irq cleared");
        wb(1'b1, REG_IRQ_MASK, 32'h8, q);
        op(8'h55, 16'h1234, 16'h0042, 1'b0, 1'b0, 16'h0010, 16'h0001, 3'h0);
        repeat (3) @(negedge mclk);
        check({irq, wide_accumulator}, {1'b1, ea}, "illegal code");
        wb(1'b0, 8'h3c, 32'h0, q);
        check(q, 32'h0, "unmapped read");
        final_report();
    end

    initial begin
        #100000;
        err_count++;
        final_report();
    end
endmodule : tb
